// >>> design/adc_scan_test_regs.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
// Contract
// - each set mask bit puts its input in the scan; clear bits drop it
// - test registers accept writes only after unlock code is written
// - test voltage bit set connects channel six to internal test voltage
// - bit-walk enable set overrides test voltage select; no connection
// - test control bit 0 enables bit-walk mode of bit decisions
// - low forced-sample register supplies pattern bits 7 down to 0
// - high forced-sample register supplies pattern bits 15 down to 8
// - forced pattern applies only while test features are enabled
// - auto mode with run set converts masked channels ascending
module adc_scan_test_regs #(
  parameter int unsigned CHANNELS = adc_scan_test_pkg::SCAN_CHANNELS
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        conv_done,
  output logic             conv_start,
  output logic      [2:0]  scan_channel,
  output logic             scan_active,
  output logic             channel_six_test_connect,
  output logic             bit_decision_walk_enable,
  output logic             forced_pattern_enable,
  output logic      [15:0] forced_pattern
);

  if (CHANNELS != 8) begin : g_chk
    $error("adc_scan_test_regs: mask register is eight bits wide");
  end

  logic [7:0]  scan_config_reg;
  logic [7:0]  scan_channel_mask_reg;
  logic [7:0]  test_unlock_reg;
  logic [7:0]  test_control_reg;
  logic [7:0]  forced_sample_low_reg;
  logic [7:0]  forced_sample_high_reg;
  logic [7:0]  rdata_next;
  logic        test_unlocked;
  logic        test_wr_allow;
  logic        internal_test_voltage_select;
  logic        walk_bit;
  logic [1:0]  scan_mode_select;
  logic        scan_run;

  test_write_gate u_gate (
    .reg_addr      (reg_addr),
    .reg_wr        (reg_wr),
    .unlock_value  (test_unlock_reg),
    .test_unlocked (test_unlocked),
    .test_wr_allow (test_wr_allow)
  );

  assign scan_mode_select = scan_config_reg[
    adc_scan_test_pkg::SCAN_MODE_LSB +: 2];
  assign scan_run = scan_config_reg[adc_scan_test_pkg::SCAN_RUN_BIT];
  assign internal_test_voltage_select =
    test_control_reg[adc_scan_test_pkg::TEST_VOLTAGE_BIT];
  assign walk_bit = test_control_reg[adc_scan_test_pkg::BIT_WALK_BIT];

  // scan configuration: mode and run bits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scan_config_reg <= adc_scan_test_pkg::SCAN_CONFIG_RESET;
    end else if (reg_wr &&
                 reg_addr == adc_scan_test_pkg::SCAN_CONFIG_ADDR) begin
      scan_config_reg <= reg_wdata & adc_scan_test_pkg::SCAN_CONFIG_MASK;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scan_channel_mask_reg <= adc_scan_test_pkg::SCAN_MASK_RESET;
    end else if (reg_wr &&
                 reg_addr == adc_scan_test_pkg::SCAN_MASK_ADDR) begin
      scan_channel_mask_reg <= reg_wdata;
    end
  end

  // the key itself is always writable; writing anything else relocks
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      test_unlock_reg <= adc_scan_test_pkg::TEST_UNLOCK_RESET;
    end else if (reg_wr &&
                 reg_addr == adc_scan_test_pkg::TEST_UNLOCK_ADDR) begin
      test_unlock_reg <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      test_control_reg <= adc_scan_test_pkg::TEST_CONTROL_RESET;
    end else if (test_wr_allow &&
                 reg_addr == adc_scan_test_pkg::TEST_CONTROL_ADDR) begin
      test_control_reg <= reg_wdata &
                          adc_scan_test_pkg::TEST_CONTROL_MASK;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      forced_sample_low_reg <= adc_scan_test_pkg::FORCED_LOW_RESET;
    end else if (test_wr_allow &&
                 reg_addr == adc_scan_test_pkg::FORCED_LOW_ADDR) begin
      forced_sample_low_reg <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      forced_sample_high_reg <= adc_scan_test_pkg::FORCED_HIGH_RESET;
    end else if (test_wr_allow &&
                 reg_addr == adc_scan_test_pkg::FORCED_HIGH_ADDR) begin
      forced_sample_high_reg <= reg_wdata;
    end
  end

  // read decode; unmapped offsets answer zero
  always_comb begin
    rdata_next = adc_scan_test_pkg::READ_IDLE_VALUE;
    case (reg_addr)
      adc_scan_test_pkg::SCAN_CONFIG_ADDR:  rdata_next = scan_config_reg;
      adc_scan_test_pkg::SCAN_MASK_ADDR:    rdata_next = scan_channel_mask_reg;
      adc_scan_test_pkg::TEST_UNLOCK_ADDR:  rdata_next = test_unlock_reg;
      adc_scan_test_pkg::TEST_CONTROL_ADDR: rdata_next = test_control_reg;
      adc_scan_test_pkg::FORCED_LOW_ADDR:   rdata_next = forced_sample_low_reg;
      adc_scan_test_pkg::FORCED_HIGH_ADDR:  rdata_next =
                                              forced_sample_high_reg;
      default:                              rdata_next =
                                              adc_scan_test_pkg::READ_IDLE_VALUE;
    endcase
  end

  // data valid only in the cycle after the read strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= adc_scan_test_pkg::READ_IDLE_VALUE;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= adc_scan_test_pkg::READ_IDLE_VALUE;
    end
  end

  // test controls toward the converter core
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      channel_six_test_connect <= 1'b0;
      bit_decision_walk_enable <= 1'b0;
    end else begin
      // walk mode would corrupt the test voltage reading, so it wins
      channel_six_test_connect <= internal_test_voltage_select &&
                                  !walk_bit;
      bit_decision_walk_enable <= walk_bit;
    end
  end

  // pattern held at zero while locked so a stale value never leaks out
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      forced_pattern_enable <= 1'b0;
      forced_pattern        <= 16'h0000;
    end else begin
      forced_pattern_enable <= test_unlocked;
      forced_pattern <= test_unlocked ?
        {forced_sample_high_reg, forced_sample_low_reg} : 16'h0000;
    end
  end

  scan_sequencer #(
    .CHANNELS (CHANNELS),
    .IDX_W    (3)
  ) u_seq (
    .core_clk          (core_clk),
    .rst               (rst),
    .scan_mode_select  (scan_mode_select),
    .scan_run          (scan_run),
    .scan_channel_mask (scan_channel_mask_reg),
    .conv_done         (conv_done),
    .conv_start        (conv_start),
    .scan_channel      (scan_channel),
    .scan_active       (scan_active)
  );

  property p_locked_write_ignored;
    @(posedge core_clk) disable iff (rst)
      (reg_wr && test_unlock_reg != adc_scan_test_pkg::TEST_UNLOCK_CODE)
      |=> $stable(test_control_reg) && $stable(forced_sample_low_reg) &&
          $stable(forced_sample_high_reg);
  endproperty
  a_locked_write_ignored: assert property (p_locked_write_ignored)
    else $error("test register changed while locked");

  property p_unlocked_write_taken;
    @(posedge core_clk) disable iff (rst)
      (reg_wr && reg_addr == adc_scan_test_pkg::FORCED_HIGH_ADDR &&
       test_unlock_reg == adc_scan_test_pkg::TEST_UNLOCK_CODE)
      |=> forced_sample_high_reg == $past(reg_wdata);
  endproperty
  a_unlocked_write_taken: assert property (p_unlocked_write_taken)
    else $error("unlocked test write was lost");

  property p_test_voltage_connect;
    @(posedge core_clk) disable iff (rst)
      (internal_test_voltage_select && !walk_bit) |=>
        channel_six_test_connect;
  endproperty
  a_test_voltage_connect: assert property (p_test_voltage_connect)
    else $error("channel six not connected to test voltage");

  property p_walk_overrides;
    @(posedge core_clk) disable iff (rst)
      walk_bit |=> !channel_six_test_connect;
  endproperty
  a_walk_overrides: assert property (p_walk_overrides)
    else $error("test voltage connected during bit walk");

  property p_walk_follows;
    @(posedge core_clk) disable iff (rst)
      1'b1 |=> bit_decision_walk_enable == $past(walk_bit);
  endproperty
  a_walk_follows: assert property (p_walk_follows)
    else $error("bit walk output does not follow control bit");

  property p_pattern_low;
    @(posedge core_clk) disable iff (rst)
      test_unlocked |=> forced_pattern[7:0] == $past(forced_sample_low_reg);
  endproperty
  a_pattern_low: assert property (p_pattern_low)
    else $error("low pattern byte wrong");

  property p_pattern_high;
    @(posedge core_clk) disable iff (rst)
      test_unlocked |=>
        forced_pattern[15:8] == $past(forced_sample_high_reg);
  endproperty
  a_pattern_high: assert property (p_pattern_high)
    else $error("high pattern byte wrong");

  property p_pattern_gated;
    @(posedge core_clk) disable iff (rst)
      !test_unlocked |=> !forced_pattern_enable && forced_pattern == 16'h0000;
  endproperty
  a_pattern_gated: assert property (p_pattern_gated)
    else $error("forced pattern applied while test features off");

  property p_reserved_zero;
    @(posedge core_clk) disable iff (rst)
      (reg_rd && reg_addr == adc_scan_test_pkg::TEST_CONTROL_ADDR) |=>
        (reg_rdata & ~adc_scan_test_pkg::TEST_CONTROL_MASK) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved test control bits read nonzero");

  property p_mask_write;
    @(posedge core_clk) disable iff (rst)
      (reg_wr && reg_addr == adc_scan_test_pkg::SCAN_MASK_ADDR) |=>
        scan_channel_mask_reg == $past(reg_wdata);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("scan mask write was lost");

  property p_unlock_write;
    @(posedge core_clk) disable iff (rst)
      (reg_wr && reg_addr == adc_scan_test_pkg::TEST_UNLOCK_ADDR) |=>
        test_unlock_reg == $past(reg_wdata);
  endproperty
  a_unlock_write: assert property (p_unlock_write)
    else $error("unlock register write was lost");

  property p_low_write_taken;
    @(posedge core_clk) disable iff (rst)
      (reg_wr && reg_addr == adc_scan_test_pkg::FORCED_LOW_ADDR &&
       test_unlock_reg == adc_scan_test_pkg::TEST_UNLOCK_CODE)
      |=> forced_sample_low_reg == $past(reg_wdata);
  endproperty
  a_low_write_taken: assert property (p_low_write_taken)
    else $error("unlocked low pattern write was lost");

  property p_control_write_taken;
    @(posedge core_clk) disable iff (rst)
      (reg_wr && reg_addr == adc_scan_test_pkg::TEST_CONTROL_ADDR &&
       test_unlock_reg == adc_scan_test_pkg::TEST_UNLOCK_CODE)
      |=> test_control_reg ==
          ($past(reg_wdata) & adc_scan_test_pkg::TEST_CONTROL_MASK);
  endproperty
  a_control_write_taken: assert property (p_control_write_taken)
    else $error("unlocked test control write was lost");

  property p_voltage_clear;
    @(posedge core_clk) disable iff (rst)
      !internal_test_voltage_select |=> !channel_six_test_connect;
  endproperty
  a_voltage_clear: assert property (p_voltage_clear)
    else $error("channel six tied to test voltage while select clear");

  property p_pattern_enabled;
    @(posedge core_clk) disable iff (rst)
      test_unlocked |=> forced_pattern_enable;
  endproperty
  a_pattern_enabled: assert property (p_pattern_enabled)
    else $error("forced pattern not applied while enabled");

  property p_scan_stops;
    @(posedge core_clk) disable iff (rst)
      !(scan_run && scan_mode_select == adc_scan_test_pkg::SCAN_MODE_AUTO)
      |=> !scan_active;
  endproperty
  a_scan_stops: assert property (p_scan_stops)
    else $error("scan kept running after run or auto mode dropped");

  property p_control_readback;
    @(posedge core_clk) disable iff (rst)
      (reg_rd && reg_addr == adc_scan_test_pkg::TEST_CONTROL_ADDR) |=>
        reg_rdata == $past(test_control_reg);
  endproperty
  a_control_readback: assert property (p_control_readback)
    else $error("test control readback differs from stored value");

endmodule

// >>> design/scan_sequencer.sv
`timescale 1ns/100ps
module scan_sequencer #(
  parameter int unsigned CHANNELS = adc_scan_test_pkg::SCAN_CHANNELS,
  parameter int unsigned IDX_W    = $clog2(CHANNELS)
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic [1:0]          scan_mode_select,
  input  wire logic                scan_run,
  input  wire logic [CHANNELS-1:0] scan_channel_mask,
  input  wire logic                conv_done,
  output logic                     conv_start,
  output logic [IDX_W-1:0]         scan_channel,
  output logic                     scan_active
);

  if (CHANNELS < 2 || CHANNELS > 8 || IDX_W != $clog2(CHANNELS)) begin : g_chk
    $error("scan_sequencer: CHANNELS must be 2..8");
  end

  typedef enum logic [1:0] {
    SEQ_IDLE    = 2'b01,
    SEQ_CONVERT = 2'b10
  } seq_state_e;

  seq_state_e state_reg;
  logic       go;

  // first enabled channel at or after the start point, wrapping
  function automatic logic [IDX_W-1:0] next_ch(
    input logic [CHANNELS-1:0] m,
    input logic [IDX_W-1:0]    cur,
    input logic                from_zero
  );
    int   k;
    logic found;
    next_ch = cur;
    found = 1'b0;
    for (int i = 0; i < CHANNELS; i++) begin
      k = from_zero ? i : (int'(cur) + i + 1) % CHANNELS;
      if (!found && m[k]) begin
        next_ch = IDX_W'(k);
        found = 1'b1;
      end
    end
  endfunction

  assign go = scan_run &&
              (scan_mode_select == adc_scan_test_pkg::SCAN_MODE_AUTO);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg    <= SEQ_IDLE;
      conv_start   <= 1'b0;
      scan_channel <= '0;
      scan_active  <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      case (state_reg)
        SEQ_IDLE: begin
          if (go && |scan_channel_mask) begin
            scan_channel <= next_ch(scan_channel_mask, '0, 1'b1);
            conv_start   <= 1'b1;
            scan_active  <= 1'b1;
            state_reg    <= SEQ_CONVERT;
          end
        end
        SEQ_CONVERT: begin
          // an in-flight conversion is abandoned when the run bit drops
          if (!go || !(|scan_channel_mask)) begin
            scan_active <= 1'b0;
            state_reg   <= SEQ_IDLE;
          end else if (conv_done) begin
            scan_channel <= next_ch(scan_channel_mask, scan_channel,
                                    1'b0);
            conv_start   <= 1'b1;
          end
        end
        default: begin
          scan_active <= 1'b0;
          state_reg   <= SEQ_IDLE;
        end
      endcase
    end
  end

  logic [CHANNELS-1:0] mask_seen;
  logic [IDX_W-1:0]    last_ch;
  logic                started;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mask_seen <= '0;
      last_ch   <= '0;
      started   <= 1'b0;
    end else begin
      mask_seen <= scan_channel_mask;
      if (conv_start) begin
        last_ch <= scan_channel;
      end
      started <= scan_active && (started || conv_start);
    end
  end

  property p_start_in_mask;
    @(posedge core_clk) disable iff (rst)
      conv_start |-> mask_seen[scan_channel];
  endproperty
  a_start_in_mask: assert property (p_start_in_mask)
    else $error("conversion started on a masked channel");

  property p_ascending;
    @(posedge core_clk) disable iff (rst)
      (conv_start && started) |->
        scan_channel == next_ch(mask_seen, last_ch, 1'b0);
  endproperty
  a_ascending: assert property (p_ascending)
    else $error("scan skipped or reversed channel order");

  property p_no_scan_unless_auto;
    @(posedge core_clk) disable iff (rst)
      !go |=> !conv_start;
  endproperty
  a_no_scan_unless_auto: assert property (p_no_scan_unless_auto)
    else $error("scan ran outside auto mode");

endmodule

// >>> design/test_write_gate.sv
`timescale 1ns/100ps
module test_write_gate (
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] unlock_value,
  output logic            test_unlocked,
  output logic            test_wr_allow
);

  function automatic logic is_test_addr(input logic [7:0] a);
    is_test_addr = (a == adc_scan_test_pkg::TEST_CONTROL_ADDR) ||
                   (a == adc_scan_test_pkg::FORCED_LOW_ADDR) ||
                   (a == adc_scan_test_pkg::FORCED_HIGH_ADDR);
  endfunction

  // any value but the code keeps the group locked
  assign test_unlocked = (unlock_value ==
                          adc_scan_test_pkg::TEST_UNLOCK_CODE);
  assign test_wr_allow = reg_wr && is_test_addr(reg_addr) &&
                         test_unlocked;

endmodule

// >>> include/adc_scan_test_pkg.sv
package adc_scan_test_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] SCAN_CONFIG_ADDR   = 8'h10;
  localparam logic [7:0] SCAN_MASK_ADDR     = 8'h12;
  localparam logic [7:0] TEST_UNLOCK_ADDR   = 8'hBF;
  localparam logic [7:0] TEST_CONTROL_ADDR  = 8'hC0;
  localparam logic [7:0] FORCED_LOW_ADDR    = 8'hC1;
  localparam logic [7:0] FORCED_HIGH_ADDR   = 8'hC2;

  localparam logic [7:0] TEST_UNLOCK_CODE   = 8'h96;

  // reset values
  localparam logic [7:0] SCAN_CONFIG_RESET  = 8'h00;
  localparam logic [7:0] SCAN_MASK_RESET    = 8'h00;
  localparam logic [7:0] TEST_UNLOCK_RESET  = 8'h00;
  localparam logic [7:0] TEST_CONTROL_RESET = 8'h00;
  localparam logic [7:0] FORCED_LOW_RESET   = 8'h00;
  localparam logic [7:0] FORCED_HIGH_RESET  = 8'h00;
  localparam logic [7:0] READ_IDLE_VALUE    = 8'h00;

  // field positions
  localparam int unsigned SCAN_RUN_BIT      = 4;
  localparam int unsigned SCAN_MODE_LSB     = 0;
  localparam int unsigned TEST_VOLTAGE_BIT  = 4;
  localparam int unsigned BIT_WALK_BIT      = 0;

  // implemented bits; the rest read as zero
  localparam logic [7:0] SCAN_CONFIG_MASK   = 8'h13;
  localparam logic [7:0] TEST_CONTROL_MASK  = 8'h11;

  localparam logic [1:0] SCAN_MODE_AUTO     = 2'h1;
  localparam int unsigned SCAN_CHANNELS     = 8;

endpackage

// >>> testbench/adc_scan_test_regs_tb_top.sv
`timescale 1ns/100ps
module adc_scan_test_regs_tb_top;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } row_s;

  logic        core_clk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        conv_done;
  logic        conv_start;
  logic [2:0]  scan_channel;
  logic        scan_active;
  logic        channel_six_test_connect;
  logic        bit_decision_walk_enable;
  logic        forced_pattern_enable;
  logic [15:0] forced_pattern;
  int          error_cnt;
  int          n_checks;
  row_s        rows [8];
  logic [7:0]  ctl_val [4];
  logic [3:0]  ch6_exp;
  logic [3:0]  walk_exp;
  logic [7:0]  cfg_bad [3];

  adc_scan_test_regs adc_scan_test_regs_inst (
    .core_clk                 (core_clk),
    .rst                      (rst),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_rdata                (reg_rdata),
    .conv_done                (conv_done),
    .conv_start               (conv_start),
    .scan_channel             (scan_channel),
    .scan_active              (scan_active),
    .channel_six_test_connect (channel_six_test_connect),
    .bit_decision_walk_enable (bit_decision_walk_enable),
    .forced_pattern_enable    (forced_pattern_enable),
    .forced_pattern           (forced_pattern)
  );

  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // data checked in its one valid cycle, then idle value the cycle after
  task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    check("reg_rdata", {8'h00, reg_rdata}, {8'h00, e});
    @(negedge core_clk);
    check("reg_rdata idle", {8'h00, reg_rdata}, 16'h0000);
  endtask

  // derived outputs lag their register by one edge
  task automatic settle;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic wait_start(input logic [2:0] ch);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (conv_start !== 1'b1 && n < 20);
    check("conv_start", {15'h0000, conv_start}, 16'h0001);
    check("scan_channel", {13'h0000, scan_channel}, {13'h0000, ch});
    check("scan_active", {15'h0000, scan_active}, 16'h0001);
    @(posedge core_clk);
    conv_done <= 1'b1;
    @(posedge core_clk);
    conv_done <= 1'b0;
  endtask

  task automatic scan(input logic [7:0] m, input logic [2:0] c0,
                      input logic [2:0] c1, input logic [2:0] c2);
    wr(adc_scan_test_pkg::SCAN_MASK_ADDR, m);
    wr(adc_scan_test_pkg::SCAN_CONFIG_ADDR, 8'h11);
    wait_start(c0);
    wait_start(c1);
    wait_start(c2);
    wr(adc_scan_test_pkg::SCAN_CONFIG_ADDR, 8'h00);
    settle();
    check("scan_active off", {15'h0000, scan_active}, 16'h0000);
  endtask

  task automatic check_outs(input logic c6, input logic wk,
                            input logic en, input logic [15:0] pat);
    check("ch6_connect", {15'h0000, channel_six_test_connect}, {15'h0000, c6});
    check("walk_enable", {15'h0000, bit_decision_walk_enable}, {15'h0000, wk});
    check("pattern_enable", {15'h0000, forced_pattern_enable}, {15'h0000, en});
    check("forced_pattern", forced_pattern, pat);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // whole run is well under 1000 cycles
  initial begin
    #(100 * 5000);
    error_cnt++;
    stop_test();
  end

  initial begin
    rst       = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    conv_done = 1'b0;
    error_cnt = 0;
    n_checks  = 0;
    rows = '{'{8'h12, 8'hA5, 8'hA5}, '{8'hC0, 8'hFF, 8'h11},
             '{8'hC0, 8'h10, 8'h10}, '{8'hC1, 8'h3C, 8'h3C},
             '{8'hC2, 8'hC3, 8'hC3}, '{8'h10, 8'hFF, 8'h13},
             '{8'h55, 8'hAA, 8'h00}, '{8'hBF, 8'h96, 8'h96}};
    ctl_val  = '{8'h10, 8'h11, 8'h01, 8'h00};
    ch6_exp  = 4'h8;
    walk_exp = 4'h6;
    cfg_bad  = '{8'h12, 8'h01, 8'h13};
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;

    foreach (rows[k]) rd_check(rows[k].addr, 8'h00);
    rd_check(adc_scan_test_pkg::SCAN_CONFIG_ADDR, 8'h00);
    check_outs(1'b0, 1'b0, 1'b0, 16'h0000);
    wr(adc_scan_test_pkg::TEST_CONTROL_ADDR, 8'h11);
    rd_check(adc_scan_test_pkg::TEST_CONTROL_ADDR, 8'h00);
    $display("done: reset and locked write");

    wr(adc_scan_test_pkg::TEST_UNLOCK_ADDR, 8'h96);
    foreach (rows[k]) begin
      wr(rows[k].addr, rows[k].wdata);
      rd_check(rows[k].addr, rows[k].rexp);
    end
    $display("done: register table");

    foreach (ctl_val[k]) begin
      wr(adc_scan_test_pkg::TEST_CONTROL_ADDR, ctl_val[k]);
      settle();
      check_outs(ch6_exp[3-k], walk_exp[3-k], 1'b1, 16'hC33C);
    end
    $display("done: test control");

    wr(adc_scan_test_pkg::FORCED_LOW_ADDR, 8'h5A);
    wr(adc_scan_test_pkg::FORCED_HIGH_ADDR, 8'hA5);
    settle();
    check_outs(1'b0, 1'b0, 1'b1, 16'hA55A);
    // one below the code must relock
    wr(adc_scan_test_pkg::TEST_UNLOCK_ADDR, 8'h95);
    settle();
    check_outs(1'b0, 1'b0, 1'b0, 16'h0000);
    wr(adc_scan_test_pkg::FORCED_LOW_ADDR, 8'hFF);
    wr(adc_scan_test_pkg::TEST_CONTROL_ADDR, 8'h11);
    rd_check(adc_scan_test_pkg::FORCED_LOW_ADDR, 8'h5A);
    rd_check(adc_scan_test_pkg::TEST_CONTROL_ADDR, 8'h00);
    wr(adc_scan_test_pkg::TEST_UNLOCK_ADDR, 8'h96);
    settle();
    check_outs(1'b0, 1'b0, 1'b1, 16'hA55A);
    $display("done: forced pattern and relock");

    scan(8'h05, 3'h0, 3'h2, 3'h0);
    scan(8'hA4, 3'h2, 3'h5, 3'h7);
    scan(8'h80, 3'h7, 3'h7, 3'h7);
    foreach (cfg_bad[k]) begin
      wr(adc_scan_test_pkg::SCAN_CONFIG_ADDR, cfg_bad[k]);
      repeat (4) @(negedge core_clk);
      check("scan_active", {15'h0000, scan_active}, 16'h0000);
    end
    wr(adc_scan_test_pkg::SCAN_MASK_ADDR, 8'h00);
    wr(adc_scan_test_pkg::SCAN_CONFIG_ADDR, 8'h11);
    repeat (4) @(negedge core_clk);
    check("scan_active", {15'h0000, scan_active}, 16'h0000);
    $display("done: scan sequence");

    // reset in mid-scan while unlocked: all back to reset values
    wr(adc_scan_test_pkg::SCAN_MASK_ADDR, 8'h01);
    repeat (2) @(negedge core_clk);
    check("scan_active", {15'h0000, scan_active}, 16'h0001);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    check_outs(1'b0, 1'b0, 1'b0, 16'h0000);
    check("conv_start", {15'h0000, conv_start}, 16'h0000);
    check("scan_active", {15'h0000, scan_active}, 16'h0000);
    foreach (rows[k]) rd_check(rows[k].addr, 8'h00);
    $display("done: reset in mid-run");
    stop_test();
  end
endmodule
